// ===== slp_control.sv
// Sleep entry, wakeup, reset sequencing, processor address decode and the
// processor control registers. Assumes a processor-side register port on
// this clock; pin-level wake sources arrive asynchronously.
//
// Functional notes
// - Sleep bit 1 of power control enters sleep
// - GPIO configuration kept unchanged while sleeping
// - External address outputs driven low while sleeping
// - Sleep disables crystal drive, PLL, booster, transceivers
// - Processor suspended until enabled wake event
// - Resume execution within 200 us after wake
// - USB resume, VBUS level, role, IRQ edges wake
// - Port reads wake device; read data is dummy
// - USB resume wake raises host port interrupt
// - Reset pin restores all register defaults
// - Fetch at 0xFF00 200 us after reset
// - USB reset clears only 0xC090 and 0xC0B0
// - Single byte-addressable 64K decoded space
// - Registers at 0xC000, ROM at 0xE000-0xFFFF
// - Chip selects inactive on internal accesses
// - RAM merge maps 0x4000-0xBFFF to RAM select
// - 0xC100-0xDFFF maps to ROM select
// - External address reaches 512 KB via pages
// - Flags register read-only, GIE and NVCZ
// - N from result MSB, Z on zero result
// - C on carry or borrow, V on overflow
// - Wake enables qualify sources; sleep or halt
`timescale 1ns/100ps
`default_nettype none
`include "slp_map.svh"

module slp_control #(
  parameter int unsigned STARTUP_CYCLES = `SLP_STARTUP_CYCLES,
  parameter int unsigned EXT_ADDR_W     = 19,
  parameter int unsigned PAGE_W         = 4,
  parameter logic [15:0] REVISION_ID    = 16'h0001 // Arbitrary value
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_en,
  input  wire logic                  usb_bus_reset,
  input  wire logic                  cpu_req,
  input  wire logic                  cpu_we,
  input  wire logic [15:0]           cpu_addr,
  input  wire logic [15:0]           cpu_wdata,
  output logic      [15:0]           cpu_rdata,
  output logic                       cpu_fetch_valid,
  output logic      [15:0]           cpu_fetch_addr,
  input  wire logic                  ram_merge_en,
  input  wire logic [PAGE_W-1:0]     ext_page,
  input  wire logic                  flags_update,
  input  wire logic [15:0]           alu_result,
  input  wire logic                  alu_carry,
  input  wire logic                  alu_overflow,
  input  wire logic                  global_int_en,
  input  wire logic [3:0]            usb_resume,
  input  wire logic                  otg_bus_power_sense,
  input  wire logic                  otg_role_input,
  input  wire logic                  ext_interrupt_zero,
  input  wire logic                  ext_interrupt_one,
  input  wire logic                  parallel_host_port_read,
  input  wire logic                  fast_serial_port_read,
  input  wire logic                  spi_slave_read,
  input  wire logic                  boost_ok,
  output logic                       ext_ram_region_select_n,
  output logic                       ext_rom_region_select_n,
  output logic      [EXT_ADDR_W-1:0] ext_addr,
  output logic                       crystal_drive_output,
  output logic                       pll_enable,
  output logic                       booster_enable,
  output logic                       usb_xcvr_enable,
  output logic                       cpu_run,
  output logic                       cpu_halted,
  output logic                       gpio_hold,
  output logic                       port_read_dummy,
  output logic                       host_port_interrupt_out,
  output logic      [15:0]           usb_reg_a,
  output logic      [15:0]           usb_reg_b
);

  slp_pkg::slp_state_t state_reg;
  logic [31:0] startup_cnt_reg;

  logic [15:0] pwr_reg;
  logic [15:0] bank_reg;
  logic [15:0] div_reg;
  logic [15:0] ien_reg;
  logic [15:0] bkpt_reg;
  logic [15:0] usb_diag_reg;
  logic [15:0] mem_diag_reg;
  logic [4:0]  flags_reg;

  logic [8:0]  pin_s1;
  logic [8:0]  pin_s2;
  logic [8:0]  pin_s3;
  logic [8:0]  pin_lvl_reg;

  logic        wake;
  logic        usb_wake;
  logic        port_wake;
  logic        otg_wake;
  logic        irq_wake;
  logic        wr;
  slp_pkg::slp_target_t tgt;

  // Address region of a processor access
  function automatic slp_pkg::slp_target_t decode(input logic [15:0] a,
                                                  input logic        merge);
    if (a >= `SLP_ROM_BASE)
      decode = slp_pkg::SLP_TGT_ROM;
    else if (a >= `SLP_XROM_BASE)
      decode = slp_pkg::SLP_TGT_EXT_ROM;
    else if (a >= `SLP_REG_BASE)
      decode = slp_pkg::SLP_TGT_REGS;
    else if (a >= `SLP_XRAM_BASE && merge)
      decode = slp_pkg::SLP_TGT_EXT_RAM;
    else
      decode = slp_pkg::SLP_TGT_INT_RAM;
  endfunction

  // A settled sync pair that differs from the tracked level is one edge
  function automatic logic edge_seen(input logic s2, input logic s3,
                                     input logic lvl);
    edge_seen = s2 == s3 && s3 != lvl;
  endfunction

  assign tgt = decode(cpu_addr, ram_merge_en);
  // Stores outside RUN are dropped so a wake cannot race them
  assign wr  = cpu_req && cpu_we && state_reg == slp_pkg::SLP_RUN;

  // Three-stage pin sync; a change counts once stages two and three agree
  // Boost status rides the same chain; only a read uses it
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1      <= '0;
      pin_s2      <= '0;
      pin_s3      <= '0;
      pin_lvl_reg <= '0;
    end else if (clock_en) begin
      pin_s1 <= {usb_resume, otg_bus_power_sense, otg_role_input,
                 ext_interrupt_zero, ext_interrupt_one, boost_ok};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 9; i++) begin
        if (pin_s2[i] == pin_s3[i])
          pin_lvl_reg[i] <= pin_s3[i];
      end
    end
  end

  // Wake qualification by the enable bits of power control
  always_comb begin
    usb_wake = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // Resume is a level; usb_resume[i] sits at chain bit 5 + i
      if (pwr_reg[`SLP_PWR_USB_LO_BIT + i] &&
          pin_s2[5+i] == pin_s3[5+i] && pin_s3[5+i])
        usb_wake = 1'b1;
    end
    port_wake = (parallel_host_port_read && pwr_reg[`SLP_PWR_HOST_PORT_BIT])
             || (fast_serial_port_read && pwr_reg[`SLP_PWR_SERIAL_BIT])
             || (spi_slave_read && pwr_reg[`SLP_PWR_SPI_BIT]);
    otg_wake  = pwr_reg[`SLP_PWR_OTG_BIT] &&
                (pin_lvl_reg[4] ||
                 edge_seen(pin_s2[3], pin_s3[3], pin_lvl_reg[3]));
    irq_wake  = pwr_reg[`SLP_PWR_GPI_BIT] &&
                (edge_seen(pin_s2[2], pin_s3[2], pin_lvl_reg[2]) ||
                 edge_seen(pin_s2[1], pin_s3[1], pin_lvl_reg[1]));
    wake      = usb_wake || port_wake || otg_wake || irq_wake;
  end

  // Power sequencing: run, sleep, PLL restart
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg       <= slp_pkg::SLP_STARTUP;
      startup_cnt_reg <= '0;
    end else if (clock_en) begin
      case (state_reg)
        slp_pkg::SLP_RUN: begin
          if (wr && cpu_addr == `SLP_ADDR_POWER_CONTROL &&
              cpu_wdata[`SLP_PWR_SLEEP_BIT])
            state_reg <= slp_pkg::SLP_SLEEP;
        end
        slp_pkg::SLP_SLEEP: begin
          // Every wake waits the full PLL lock time
          startup_cnt_reg <= '0;
          if (wake)
            state_reg <= slp_pkg::SLP_STARTUP;
        end
        slp_pkg::SLP_STARTUP: begin
          if (startup_cnt_reg >= STARTUP_CYCLES - 1)
            state_reg <= slp_pkg::SLP_RUN;
          else
            startup_cnt_reg <= startup_cnt_reg + 32'd1;
        end
        default: state_reg <= slp_pkg::SLP_RUN;
      endcase
    end
  end

  // Analog and clock controls follow the sleep state
  always_ff @(posedge clock) begin
    if (rst) begin
      crystal_drive_output <= 1'b1;
      pll_enable           <= 1'b1;
      booster_enable       <= 1'b1;
      usb_xcvr_enable      <= 1'b0;
      cpu_run              <= 1'b0;
      gpio_hold            <= 1'b0;
    end else if (clock_en) begin
      crystal_drive_output <= state_reg != slp_pkg::SLP_SLEEP;
      pll_enable           <= state_reg != slp_pkg::SLP_SLEEP;
      booster_enable       <= state_reg != slp_pkg::SLP_SLEEP;
      // Transceivers stay off until the clock is stable
      usb_xcvr_enable      <= state_reg == slp_pkg::SLP_RUN;
      cpu_run              <= state_reg == slp_pkg::SLP_RUN &&
                              !pwr_reg[`SLP_PWR_HALT_BIT];
      gpio_hold            <= state_reg == slp_pkg::SLP_SLEEP;
    end
  end

  // Boot fetch at the reset vector once startup completes
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_fetch_valid <= 1'b0;
      cpu_fetch_addr  <= `SLP_BOOT_VECTOR;
    end else if (clock_en) begin
      cpu_fetch_valid <= 1'b0;
      if (state_reg == slp_pkg::SLP_STARTUP &&
          startup_cnt_reg >= STARTUP_CYCLES - 1) begin
        cpu_fetch_valid <= 1'b1;
        cpu_fetch_addr  <= `SLP_BOOT_VECTOR;
      end
    end
  end

  // Wake side effects: host interrupt on USB resume, dummy read marker
  always_ff @(posedge clock) begin
    if (rst) begin
      host_port_interrupt_out <= 1'b0;
      port_read_dummy         <= 1'b0;
    end else if (clock_en) begin
      port_read_dummy <= state_reg == slp_pkg::SLP_SLEEP && port_wake;
      // Any power control write acknowledges the interrupt
      if (state_reg == slp_pkg::SLP_SLEEP && usb_wake)
        host_port_interrupt_out <= 1'b1;
      else if (wr && cpu_addr == `SLP_ADDR_POWER_CONTROL)
        host_port_interrupt_out <= 1'b0;
    end
  end

  // Control registers; pin reset restores every default
  always_ff @(posedge clock) begin
    if (rst) begin
      pwr_reg      <= `SLP_RST_ZERO;
      bank_reg     <= `SLP_RST_BANK_BASE;
      div_reg      <= `SLP_RST_CLK_DIVISOR;
      ien_reg      <= `SLP_RST_ZERO;
      bkpt_reg     <= `SLP_RST_ZERO;
      usb_diag_reg <= `SLP_RST_ZERO;
      mem_diag_reg <= `SLP_RST_ZERO;
    end else if (clock_en) begin
      // Sleep bit self-clears so a read shows the device awake
      if (state_reg == slp_pkg::SLP_SLEEP && wake)
        pwr_reg[`SLP_PWR_SLEEP_BIT] <= 1'b0;
      if (wr) begin
        case (cpu_addr)
          `SLP_ADDR_POWER_CONTROL: pwr_reg <= cpu_wdata & `SLP_PWR_WRITABLE;
          `SLP_ADDR_BANK_BASE:     bank_reg <= {cpu_wdata[15:4], 4'h0};
          `SLP_ADDR_CLK_DIVISOR:   div_reg  <= {12'h000, cpu_wdata[3:0]};
          `SLP_ADDR_INT_ENABLE:    ien_reg  <= cpu_wdata;
          `SLP_ADDR_BREAKPOINT:    bkpt_reg <= cpu_wdata;
          `SLP_ADDR_USB_DIAG:      usb_diag_reg <= cpu_wdata;
          `SLP_ADDR_MEM_DIAG:      mem_diag_reg <= cpu_wdata;
          default: ;
        endcase
      end
    end
  end

  // USB bus reset touches only these two registers
  always_ff @(posedge clock) begin
    if (rst) begin
      usb_reg_a <= `SLP_RST_ZERO;
      usb_reg_b <= `SLP_RST_ZERO;
    end else if (clock_en) begin
      // Bus reset wins over a store in the same cycle
      if (usb_bus_reset) begin
        usb_reg_a <= `SLP_RST_ZERO;
        usb_reg_b <= `SLP_RST_ZERO;
      end else if (wr && cpu_addr == `SLP_ADDR_USB_RST_A)
        usb_reg_a <= cpu_wdata;
      else if (wr && cpu_addr == `SLP_ADDR_USB_RST_B)
        usb_reg_b <= cpu_wdata;
    end
  end

  // ALU flags move only when a flag-setting instruction completes
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_reg <= '0;
    end else if (clock_en) begin
      // Interrupt enable is mirrored every cycle, not an ALU flag
      flags_reg[4] <= global_int_en;
      if (flags_update) begin
        flags_reg[3] <= alu_result[15];
        flags_reg[2] <= alu_overflow;
        flags_reg[1] <= alu_carry;
        flags_reg[0] <= alu_result == 16'h0000;
      end
    end
  end

  // Register read data; flags are read-only since writes never reach them
  always_ff @(posedge clock) begin
    if (rst) begin
      cpu_rdata <= '0;
    end else if (clock_en && cpu_req && !cpu_we) begin
      case (cpu_addr)
        `SLP_ADDR_CPU_FLAGS:     cpu_rdata <= {11'h000, flags_reg};
        `SLP_ADDR_BANK_BASE:     cpu_rdata <= bank_reg;
        `SLP_ADDR_REVISION:      cpu_rdata <= REVISION_ID;
        `SLP_ADDR_CLK_DIVISOR:   cpu_rdata <= div_reg;
        `SLP_ADDR_POWER_CONTROL:
          cpu_rdata <= {pwr_reg[15:3], pin_lvl_reg[0], pwr_reg[1:0]};
        `SLP_ADDR_INT_ENABLE:    cpu_rdata <= ien_reg;
        `SLP_ADDR_BREAKPOINT:    cpu_rdata <= bkpt_reg;
        `SLP_ADDR_USB_RST_A:     cpu_rdata <= usb_reg_a;
        `SLP_ADDR_USB_RST_B:     cpu_rdata <= usb_reg_b;
        // Write-only and unmapped words read as zero
        default:                 cpu_rdata <= 16'h0000;
      endcase
    end
  end

  // External memory pins; address low and selects idle during sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_ram_region_select_n <= 1'b1;
      ext_rom_region_select_n <= 1'b1;
      ext_addr                <= '0;
    end else if (clock_en) begin
      if (state_reg != slp_pkg::SLP_RUN) begin
        ext_ram_region_select_n <= 1'b1;
        ext_rom_region_select_n <= 1'b1;
        ext_addr                <= '0;
      end else begin
        ext_ram_region_select_n <= !(cpu_req &&
                                     tgt == slp_pkg::SLP_TGT_EXT_RAM);
        ext_rom_region_select_n <= !(cpu_req &&
                                     tgt == slp_pkg::SLP_TGT_EXT_ROM);
        // Page bits stand in for address bit 15
        ext_addr <= EXT_ADDR_W'({ext_page, cpu_addr[14:0]});
      end
    end
  end

  // Halt stops only the processor; clocks keep running
  always_ff @(posedge clock) begin
    if (rst)
      cpu_halted <= 1'b0;
    else if (clock_en)
      cpu_halted <= pwr_reg[`SLP_PWR_HALT_BIT];
  end

endmodule
`default_nettype wire

// ===== slp_control_bench.sv
// Self-checking bench for the sleep, reset and address decode block.
// Assumes the checker and wake model files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module slp_control_bench;
  localparam logic [15:0] REV = 16'h0001; // Arbitrary value
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  wire logic   clock_en = 1'b1;
  wire logic   boost_ok = 1'b0;
  logic        cpu_req, cpu_we, flags_update, usb_bus_reset, ram_merge_en;
  logic        alu_carry, alu_overflow, global_int_en, fire;
  logic [15:0] cpu_addr, cpu_wdata, alu_result;
  logic [3:0]  ext_page, usb_resume;
  logic [2:0]  src;
  logic        otg_bus_power_sense, otg_role_input, ext_interrupt_zero;
  logic        ext_interrupt_one, parallel_host_port_read;
  logic        fast_serial_port_read, spi_slave_read;
  logic [15:0] cpu_rdata, cpu_fetch_addr, usb_reg_a, usb_reg_b;
  logic [18:0] ext_addr;
  logic        cpu_fetch_valid, ext_ram_region_select_n;
  logic        ext_rom_region_select_n, crystal_drive_output, pll_enable;
  logic        booster_enable, usb_xcvr_enable, cpu_run, cpu_halted;
  logic        gpio_hold, port_read_dummy, host_port_interrupt_out;
  logic [15:0] q[$];
  logic        rd_d = 1'b0;
  int          n_dummy = 0;
  int          mismatches = 0;
  int          n_tests = 0;
  int          seed = 26775;
  // Wake enable per source, in model source order
  logic [15:0] wake_en [8] = '{16'h1000, 16'h0800, 16'h0800, 16'h0010,
                               16'h0010, 16'h0080, 16'h0200, 16'h0100};

  slp_control #(.STARTUP_CYCLES(8), .REVISION_ID(REV)) i_slp_control (.*);
  slp_wake_model i_slp_wake_model (.*);

  initial begin
    forever #2 clock = ~clock;
  end

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A read carries its expected data in d
  task automatic acc(input logic we, input logic [15:0] a,
                     input logic [15:0] d);
    @(posedge clock);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    if (!we) q.push_back(d);
    @(posedge clock);
    cpu_req <= 1'b0;
    cpu_we <= 1'b0;
  endtask

  task automatic wait_run();
    int k;
    k = 0;
    while (cpu_fetch_valid !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    check("fetch_valid", cpu_fetch_valid, 16'h0001);
    check("fetch_addr", cpu_fetch_addr, 16'hFF00);
    repeat (2) @(posedge clock);
  endtask

  task automatic defaults();
    acc(0, 16'hC002, 16'h0100);
    acc(0, 16'hC004, REV);
    acc(0, 16'hC008, 16'h000F);
    acc(0, 16'hC00A, 16'h0000);
    acc(0, 16'hC00E, 16'h0000);
    acc(0, 16'hC014, 16'h0000);
    acc(0, 16'hC0F0, 16'h0000);
  endtask

  always @(posedge clock) begin
    rd_d <= cpu_req && !cpu_we;
    if (port_read_dummy === 1'b1) n_dummy <= n_dummy + 1;
    if (rd_d) check("cpu_rdata", cpu_rdata, q.pop_front());
  end

  initial begin
    #40000;
    mismatches++;
    results();
  end

  initial begin
    logic [15:0] v, e, a;
    logic [3:0]  f;
    int          d0;
    {cpu_req, cpu_we, flags_update, usb_bus_reset, ram_merge_en} = '0;
    {alu_carry, alu_overflow, global_int_en, fire, src, ext_page} = '0;
    {cpu_addr, cpu_wdata, alu_result} = '0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    wait_run();
    defaults();
    v = 16'($random(seed));
    acc(1, 16'hC014, v);
    acc(1, 16'hC002, ~v);
    acc(0, 16'hC014, v);
    acc(0, 16'hC002, ~v & 16'hFFF0);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 16'h0000 : 16'($random(seed));
      f = 4'($random(seed));
      @(posedge clock);
      {alu_result, alu_carry, alu_overflow, global_int_en} <= {v, f[2:0]};
      flags_update <= 1'b1;
      @(posedge clock);
      flags_update <= 1'b0;
      {alu_result, alu_carry, alu_overflow} <= ~{v, f[2:1]};
      e = {11'h000, f[0], v[15], f[1], f[2], v == 16'h0000};
      acc(0, 16'hC000, e);
    end
    acc(1, 16'hC000, ~e);
    acc(0, 16'hC000, e);
    repeat (60) begin
      a = 16'($random(seed));
      if (a[15:8] == 8'hC0) a = a ^ 16'h1000;
      ram_merge_en <= 1'($random(seed));
      ext_page <= 4'($random(seed));
      acc(1, a, 16'($random(seed)));
    end
    v = 16'($random(seed));
    acc(1, 16'hC014, 16'h3C3C);
    acc(1, 16'hC090, v);
    acc(1, 16'hC0B0, ~v);
    @(negedge clock);
    check("usb_reg_a", usb_reg_a, v);
    check("usb_reg_b", usb_reg_b, ~v);
    @(posedge clock) usb_bus_reset <= 1'b1;
    @(posedge clock) usb_bus_reset <= 1'b0;
    @(negedge clock);
    check("usb_reg_a", usb_reg_a, 16'h0000);
    check("usb_reg_b", usb_reg_b, 16'h0000);
    acc(0, 16'hC014, 16'h3C3C);
    acc(1, 16'hC00A, 16'h0001);
    repeat (3) @(negedge clock);
    check("halted", cpu_halted, 16'h0001);
    check("cpu_run", cpu_run, 16'h0000);
    acc(1, 16'hC00A, 16'h0000);
    repeat (3) @(negedge clock);
    check("halted", cpu_halted, 16'h0000);
    check("cpu_run", cpu_run, 16'h0001);
    for (int s = 0; s < 8; s++) begin
      acc(1, 16'hC00A, wake_en[s] | 16'h0002);
      @(posedge clock) {fire, src} <= {1'b1, (s == 5) ? 3'h7 : 3'h5};
      @(posedge clock) fire <= 1'b0;
      repeat (10) @(negedge clock);
      check("cpu_run", cpu_run, 16'h0000);
      check("power", {crystal_drive_output, pll_enable, booster_enable,
                      usb_xcvr_enable}, 16'h0000);
      check("gpio_hold", gpio_hold, 16'h0001);
      d0 = n_dummy;
      @(posedge clock) {fire, src} <= {1'b1, 3'(s)};
      @(posedge clock) fire <= 1'b0;
      wait_run();
      check("host_int", host_port_interrupt_out, 16'(s == 0));
      check("dummy", 16'(n_dummy - d0), 16'(s >= 5));
      acc(0, 16'hC00A, wake_en[s]);
    end
    acc(1, 16'hC014, 16'h5A5A);
    @(posedge clock) rst <= 1'b1;
    repeat (334) @(posedge clock);
    rst <= 1'b0;
    wait_run();
    defaults();
    repeat (4) @(posedge clock);
    results();
  end
endmodule
bind slp_control slp_control_checker #(.EXT_ADDR_W(EXT_ADDR_W),
  .PAGE_W(PAGE_W)) i_slp_control_checker (.*);
`default_nettype wire

// ===== slp_control_checker.sv
// Port checker for the sleep, reset and address decode block.
// Assumes one clock, synchronous active-high reset, bound from the bench.
`timescale 1ns/100ps
`default_nettype none
module slp_control_checker #(
  parameter int unsigned EXT_ADDR_W = 19,
  parameter int unsigned PAGE_W     = 4
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  clock_en,
  input wire logic                  cpu_req,
  input wire logic [15:0]           cpu_addr,
  input wire logic                  ram_merge_en,
  input wire logic [PAGE_W-1:0]     ext_page,
  input wire logic                  ext_ram_region_select_n,
  input wire logic                  ext_rom_region_select_n,
  input wire logic [EXT_ADDR_W-1:0] ext_addr,
  input wire logic                  crystal_drive_output,
  input wire logic                  pll_enable,
  input wire logic                  booster_enable,
  input wire logic                  usb_xcvr_enable,
  input wire logic                  cpu_run,
  input wire logic                  cpu_halted,
  input wire logic                  gpio_hold,
  input wire logic                  cpu_fetch_valid,
  input wire logic [15:0]           cpu_fetch_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic go  = cpu_req && cpu_run && clock_en;
  wire logic ram = ram_merge_en && cpu_addr >= 16'h4000 && cpu_addr <= 16'hBFFF;
  wire logic rom = cpu_addr >= 16'hC100 && cpu_addr <= 16'hDFFF;
  logic [EXT_ADDR_W-1:0] exp_addr;
  always_ff @(posedge clock) begin
    exp_addr <= EXT_ADDR_W'({ext_page, cpu_addr[14:0]});
  end
  // Outputs are registered, so sleep effects are judged one cycle in
  sequence s_asleep;
    gpio_hold && $past(gpio_hold);
  endsequence
  property p_sleep_off;
    s_asleep |-> !(crystal_drive_output || pll_enable || booster_enable ||
                   usb_xcvr_enable);
  endproperty
  property p_addr_low;
    s_asleep |-> ext_addr == '0;
  endproperty
  property p_cpu_held;
    s_asleep |-> !cpu_run && !cpu_fetch_valid;
  endproperty
  property p_ram_sel;
    go && ram |=> !ext_ram_region_select_n && ext_rom_region_select_n;
  endproperty
  property p_rom_sel;
    go && rom |=> !ext_rom_region_select_n && ext_ram_region_select_n;
  endproperty
  property p_no_sel;
    go && !ram && !rom |=> ext_ram_region_select_n && ext_rom_region_select_n;
  endproperty
  property p_page;
    go && ram |=> ext_addr == exp_addr;
  endproperty
  property p_fetch;
    cpu_fetch_valid |-> cpu_fetch_addr == 16'hFF00 ##1 cpu_run;
  endproperty
  property p_boot;
    $fell(rst) |-> !cpu_fetch_valid [*4] ##[1:30] cpu_fetch_valid;
  endproperty
  property p_wake;
    $fell(gpio_hold) |-> ##[1:30] cpu_fetch_valid;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("clock or power output on while asleep");
  a_addr_low: assert property (p_addr_low)
    else $error("external address not low while asleep");
  a_cpu_held: assert property (p_cpu_held)
    else $error("processor running while asleep");
  a_ram_sel: assert property (p_ram_sel)
    else $error("ram region select wrong");
  a_rom_sel: assert property (p_rom_sel)
    else $error("rom region select wrong");
  a_no_sel: assert property (p_no_sel)
    else $error("select active on internal access");
  a_page: assert property (p_page)
    else $error("external address not page plus offset");
  a_fetch: assert property (p_fetch)
    else $error("first fetch address wrong");
  a_boot: assert property (p_boot)
    else $error("startup fetch timing wrong");
  a_wake: assert property (p_wake)
    else $error("no fetch after wake");
  property p_halt;
    cpu_halted |-> !cpu_run;
  endproperty
  a_halt: assert property (p_halt)
    else $error("processor running while halted");
  c_wake: cover property (gpio_hold ##1 !gpio_hold);
  c_ram: cover property (go && ram);
  c_rom: cover property (go && rom);
endmodule
`default_nettype wire

// ===== slp_map.svh
// Register offsets, field positions, reset values and timing counts for the
// sleep, reset and address-map control block. Definitions only.
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH

`define SLP_ADDR_CPU_FLAGS      16'hC000
`define SLP_ADDR_BANK_BASE      16'hC002
`define SLP_ADDR_REVISION       16'hC004
`define SLP_ADDR_CLK_DIVISOR    16'hC008
`define SLP_ADDR_POWER_CONTROL  16'hC00A
`define SLP_ADDR_INT_ENABLE     16'hC00E
`define SLP_ADDR_BREAKPOINT     16'hC014
`define SLP_ADDR_USB_DIAG       16'hC03C
`define SLP_ADDR_MEM_DIAG       16'hC03E
`define SLP_ADDR_USB_RST_A      16'hC090
`define SLP_ADDR_USB_RST_B      16'hC0B0

`define SLP_REG_BASE            16'hC000
`define SLP_REG_LAST            16'hC0FF
`define SLP_ROM_BASE            16'hE000
`define SLP_XRAM_BASE           16'h4000
`define SLP_XRAM_LAST           16'hBFFF
`define SLP_XROM_BASE           16'hC100
`define SLP_XROM_LAST           16'hDFFF
`define SLP_BOOT_VECTOR         16'hFF00
`define SLP_ROM_START           16'hE000

`define SLP_PWR_HALT_BIT        0
`define SLP_PWR_SLEEP_BIT       1
`define SLP_PWR_BOOST_OK_BIT    2
`define SLP_PWR_GPI_BIT         4
`define SLP_PWR_HOST_PORT_BIT   7
`define SLP_PWR_SPI_BIT         8
`define SLP_PWR_SERIAL_BIT      9
`define SLP_PWR_OTG_BIT         11
`define SLP_PWR_USB_LO_BIT      12
`define SLP_PWR_WRITABLE        16'hFB93

`define SLP_RST_BANK_BASE       16'h0100
`define SLP_RST_CLK_DIVISOR     16'h000F
`define SLP_RST_ZERO            16'h0000

`define SLP_STARTUP_US          200
`define SLP_CLOCK_MHZ           250
`define SLP_STARTUP_CYCLES      (`SLP_STARTUP_US * `SLP_CLOCK_MHZ)

`endif

// ===== slp_pkg.sv
// Types for the sleep, reset and address-map control block.
// Assumes the map header supplies all numeric constants.
package slp_pkg;
  typedef enum logic [1:0] {
    SLP_RUN,
    SLP_SLEEP,
    SLP_STARTUP
  } slp_state_t;

  typedef enum logic [2:0] {
    SLP_TGT_INT_RAM,
    SLP_TGT_EXT_RAM,
    SLP_TGT_REGS,
    SLP_TGT_EXT_ROM,
    SLP_TGT_ROM
  } slp_target_t;
endpackage

// ===== slp_wake_model.sv
// Wake sources facing the block: pin events and port reads on command.
// Assumes one-cycle fire pulses from the bench on the same clock.
`timescale 1ns/100ps
`default_nettype none
module slp_wake_model (
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [2:0] src,
  output logic      [3:0] usb_resume,
  output logic            otg_bus_power_sense,
  output logic            otg_role_input,
  output logic            ext_interrupt_zero,
  output logic            ext_interrupt_one,
  output logic            parallel_host_port_read,
  output logic            fast_serial_port_read,
  output logic            spi_slave_read
);
  logic [2:0] hold = 3'h0;
  initial begin
    {usb_resume, otg_bus_power_sense, otg_role_input} = '0;
    {ext_interrupt_zero, ext_interrupt_one} = '0;
    {parallel_host_port_read, fast_serial_port_read, spi_slave_read} = '0;
  end
  // Levels drop after six cycles so the next sleep is not cut short
  always @(posedge clock) begin
    {parallel_host_port_read, fast_serial_port_read, spi_slave_read} <= '0;
    if (hold != 3'h0) hold <= hold - 3'h1;
    if (hold == 3'h1) begin
      usb_resume <= 4'h0;
      otg_bus_power_sense <= 1'b0;
    end
    if (fire) begin
      hold <= 3'h6;
      case (src)
        3'h0: usb_resume <= 4'h1;
        3'h1: otg_bus_power_sense <= 1'b1;
        3'h2: otg_role_input <= ~otg_role_input;
        3'h3: ext_interrupt_zero <= ~ext_interrupt_zero;
        3'h4: ext_interrupt_one <= ~ext_interrupt_one;
        3'h5: parallel_host_port_read <= 1'b1;
        3'h6: fast_serial_port_read <= 1'b1;
        default: spi_slave_read <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire
